// ### hdl/dmacm_top.sv
// Command and mask ports of both DMA controllers.
// Assumes one-cycle I/O read/write strobes from the host on sys_clk_i.
// Channel requests arrive from device pins, outside the clock domain.
`timescale 1ns/1ps
module dmacm_ctrl
  import dmacm_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Decoded port strobes
  input  wire logic       bpclr_i,
  input  wire logic       cclr_i,
  input  wire logic       cmask_i,
  input  wire logic       amask_wr_i,
  input  wire logic       smask_wr_i,
  input  wire logic [7:0] wdata_i,
  // Engine side
  input  wire logic       reg16_acc_i,
  input  wire logic [3:0] tc_i,
  input  wire logic [3:0] autoinit_i,
  output logic            byte_hi_o,
  output logic [3:0]      mask_o,
  output logic            ctrl_clear_o,
  output logic [3:0]      reload_o
);
  logic       next_byte_hi;
  logic [3:0] next_mask;
  logic [3:0] next_reload;

  // ---------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------
  always_comb begin
    next_byte_hi = byte_hi_o;
    next_mask    = mask_o;
    if (reg16_acc_i) begin
      next_byte_hi = ~byte_hi_o;
    end
    if (bpclr_i) begin
      next_byte_hi = 1'b0;
    end
    if (amask_wr_i) begin
      next_mask = wdata_i[3:0];
    end
    if (smask_wr_i) begin
      next_mask[wdata_i[1:0]] = wdata_i[SMASK_SET_BIT];
    end
    if (cmask_i) begin
      next_mask = MASK_CLEAR;
    end
    // terminal count masks channel unless autoinit
    next_mask = next_mask | (tc_i & ~autoinit_i);
    next_reload = tc_i & autoinit_i;
    if (cclr_i) begin
      next_byte_hi = 1'b0;
      next_mask    = MASK_RESET;
      // Reset leaves no reload pending either
      next_reload  = 4'h0;
    end
  end

  // ---------------------------------------------------
  // Registers
  // ---------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      byte_hi_o    <= 1'b0;
      mask_o       <= MASK_RESET;
      ctrl_clear_o <= 1'b0;
      reload_o     <= 4'h0;
    end else begin
      byte_hi_o    <= next_byte_hi;
      mask_o       <= next_mask;
      ctrl_clear_o <= cclr_i;
      reload_o     <= next_reload;
    end
  end
endmodule // dmacm_ctrl

module dmacm_top
  import dmacm_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Host I/O port
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  output logic             io_rvalid_o,
  // Engine side, channels 0-3 then 4-7
  input  wire logic [1:0]  reg16_acc_i,
  input  wire logic [7:0]  terminal_count_i,
  input  wire logic [7:0]  autoinit_i,
  input  wire logic [7:0]  channel_request_i,
  output logic      [1:0]  byte_hi_o,
  output logic      [7:0]  mask_o,
  output logic      [1:0]  ctrl_clear_o,
  output logic      [7:0]  reload_o,
  output logic      [7:0]  request_ok_o
);
  logic [7:0]  next_rdata;
  logic        next_rvalid;
  logic [15:0] a_bp [2];
  logic [15:0] a_cc [2];
  logic [15:0] a_cm [2];
  logic [15:0] a_am [2];
  logic [15:0] a_sm [2];
  logic [7:0]  req_ff1;
  logic [7:0]  req_ff2;
  logic [7:0]  req_ff3;
  logic [7:0]  req_stable;
  logic [7:0]  next_req_stable;

  assign a_bp[0] = ADDR_BPCLR_LO;
  assign a_bp[1] = ADDR_BPCLR_HI;
  assign a_cc[0] = ADDR_CCLR_LO;
  assign a_cc[1] = ADDR_CCLR_HI;
  assign a_cm[0] = ADDR_CMASK_LO;
  assign a_cm[1] = ADDR_CMASK_HI;
  assign a_am[0] = ADDR_AMASK_LO;
  assign a_am[1] = ADDR_AMASK_HI;
  assign a_sm[0] = ADDR_SMASK_LO;
  assign a_sm[1] = ADDR_SMASK_HI;

  // ---------------------------------------------------
  // One controller per port group
  // ---------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_ctl
    dmacm_ctrl u_ctl (
      .sys_clk_i    (sys_clk_i),
      .rst_i        (rst_i),
      .bpclr_i      (io_wr_i && io_addr_i == a_bp[g]),
      .cclr_i       (io_wr_i && io_addr_i == a_cc[g]),
      .cmask_i      (io_wr_i && io_addr_i == a_cm[g]),
      .amask_wr_i   (io_wr_i && io_addr_i == a_am[g]),
      .smask_wr_i   (io_wr_i && io_addr_i == a_sm[g]),
      .wdata_i      (io_wdata_i),
      .reg16_acc_i  (reg16_acc_i[g]),
      .tc_i         (terminal_count_i[4*g +: 4]),
      .autoinit_i   (autoinit_i[4*g +: 4]),
      .byte_hi_o    (byte_hi_o[g]),
      .mask_o       (mask_o[4*g +: 4]),
      .ctrl_clear_o (ctrl_clear_o[g]),
      .reload_o     (reload_o[4*g +: 4])
    );
  end

  // ---------------------------------------------------
  // Request synchroniser
  // ---------------------------------------------------
  // Pins are asynchronous; three flops keep metastability out
  // A bit moves only when stages two and three agree, so a glitch is dropped
  always_comb begin
    next_req_stable = (req_stable & (req_ff2 ^ req_ff3)) | (req_ff3 & ~(req_ff2 ^ req_ff3));
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      req_ff1    <= 8'h00;
      req_ff2    <= 8'h00;
      req_ff3    <= 8'h00;
      req_stable <= 8'h00;
    end else begin
      req_ff1    <= channel_request_i;
      req_ff2    <= req_ff1;
      req_ff3    <= req_ff2;
      req_stable <= next_req_stable;
    end
  end

  // ---------------------------------------------------
  // Request gating
  // ---------------------------------------------------
  // a set mask blocks its request
  always_comb begin
    request_ok_o[7:4] = req_stable[7:4] & ~mask_o[7:4];
    request_ok_o[3:0] = req_stable[3:0] & ~mask_o[3:0] & {4{~mask_o[4 + CASCADE_CH]}};
  end

  // ---------------------------------------------------
  // Read path
  // ---------------------------------------------------
  always_comb begin
    next_rvalid = io_rd_i;
    next_rdata  = 8'h00;
    if (io_rd_i && io_addr_i == ADDR_AMASK_LO) begin
      next_rdata = {4'h0, mask_o[3:0]};
    end else if (io_rd_i && io_addr_i == ADDR_AMASK_HI) begin
      next_rdata = {4'h0, mask_o[7:4]};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      io_rdata_o  <= 8'h00;
      io_rvalid_o <= 1'b0;
    end else begin
      io_rdata_o  <= next_rdata;
      io_rvalid_o <= next_rvalid;
    end
  end

  // ---------------------------------------------------
  // Checks
  // ---------------------------------------------------
  a_clear_sets_mask: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_CCLR_LO |=> mask_o[3:0] == 4'hF && byte_hi_o[0] == 1'b0)
    else $error("controller clear did not set masks");
  a_bp_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_BPCLR_HI |=> byte_hi_o[1] == 1'b0)
    else $error("byte pointer not cleared");
  a_cmask_unmask: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_CMASK_LO && terminal_count_i[3:0] == 4'h0 |=> mask_o[3:0] == 4'h0)
    else $error("clear mask failed");
  a_amask_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_AMASK_HI && terminal_count_i[7:4] == 4'h0
    |=> mask_o[7:4] == $past(io_wdata_i[3:0]))
    else $error("all mask load wrong");
  a_read_mask: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_rd_i && io_addr_i == ADDR_AMASK_LO |=> io_rvalid_o && io_rdata_o == {4'h0, $past(mask_o[3:0])})
    else $error("mask readback wrong");
  a_tc_masks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    terminal_count_i[0] && !autoinit_i[0] && !(io_wr_i && io_addr_i == ADDR_CMASK_LO) |=> mask_o[0])
    else $error("terminal count did not mask");
  a_autoinit_reload: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    terminal_count_i[1] && autoinit_i[1] && !(io_wr_i && io_addr_i == ADDR_CCLR_LO) |=> reload_o[1])
    else $error("autoinit reload missing");
  a_toggle_ptr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg16_acc_i[0] && !(io_wr_i && (io_addr_i == ADDR_BPCLR_LO || io_addr_i == ADDR_CCLR_LO))
    |=> byte_hi_o[0] != $past(byte_hi_o[0]))
    else $error("byte pointer did not toggle");
  a_cascade_block: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    mask_o[4] |-> request_ok_o[3:0] == 4'h0)
    else $error("cascade mask leaked");
  a_strobe_once: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_CCLR_HI ##1 !(io_wr_i && io_addr_i == ADDR_CCLR_HI)
    |=> ctrl_clear_o[1] == 1'b0)
    else $error("clear strobe too long");

  // ---------------------------------------------------
  // Further checks on both controllers and the read path
  // ---------------------------------------------------
  a_clear_hi_masks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_CCLR_HI |=> mask_o[7:4] == MASK_RESET && byte_hi_o[1] == 1'b0)
    else $error("second controller clear did not set masks");
  a_bp_clear_lo: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_BPCLR_LO |=> byte_hi_o[0] == 1'b0)
    else $error("first byte pointer not cleared");
  a_cmask_hi: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_CMASK_HI && terminal_count_i[7:4] == 4'h0 |=> mask_o[7:4] == MASK_CLEAR)
    else $error("second clear mask failed");
  a_amask_lo: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_AMASK_LO && terminal_count_i[3:0] == 4'h0
    |=> mask_o[3:0] == $past(io_wdata_i[3:0]))
    else $error("first all mask load wrong");
  a_read_hi: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_rd_i && io_addr_i == ADDR_AMASK_HI |=> io_rvalid_o && io_rdata_o == {4'h0, $past(mask_o[7:4])})
    else $error("second mask readback wrong");
  a_read_upper_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_rvalid_o |-> io_rdata_o[7:4] == 4'h0)
    else $error("read upper bits not zero");
  a_reset_state: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $past(rst_i) |-> mask_o == {MASK_RESET, MASK_RESET} && byte_hi_o == 2'h0 && !io_rvalid_o)
    else $error("state after reset wrong");
  a_ctrl_clear_lo: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_CCLR_LO |=> ctrl_clear_o[0] && reload_o[3:0] == 4'h0)
    else $error("first controller clear strobe missing");
  a_smask_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_SMASK_LO && io_wdata_i[SMASK_SET_BIT] && terminal_count_i[3:0] == 4'h0
    |=> mask_o[3:0] == ($past(mask_o[3:0]) | (4'h1 << $past(io_wdata_i[1:0]))))
    else $error("single mask set wrong");
  a_smask_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == ADDR_SMASK_HI && !io_wdata_i[SMASK_SET_BIT] && terminal_count_i[7:4] == 4'h0
    |=> mask_o[7:4] == ($past(mask_o[7:4]) & ~(4'h1 << $past(io_wdata_i[1:0]))))
    else $error("single mask clear wrong");
  a_toggle_hi: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg16_acc_i[1] && !(io_wr_i && (io_addr_i == ADDR_BPCLR_HI || io_addr_i == ADDR_CCLR_HI))
    |=> byte_hi_o[1] != $past(byte_hi_o[1]))
    else $error("second byte pointer did not toggle");
  a_masked_blocked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (request_ok_o & mask_o) == 8'h00)
    else $error("masked request passed");
  a_tc_hi_masks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    terminal_count_i[4] && !autoinit_i[4] && !(io_wr_i && io_addr_i == ADDR_CMASK_HI) |=> mask_o[4])
    else $error("second terminal count did not mask");

  c_clear_hi: cover property (@(posedge sys_clk_i) io_wr_i && io_addr_i == ADDR_CCLR_HI);
  c_cascade_hold: cover property (@(posedge sys_clk_i) mask_o[4] && req_stable[0]);
  c_single_mask: cover property (@(posedge sys_clk_i) io_wr_i && io_addr_i == ADDR_SMASK_LO);
  c_tc_reload: cover property (@(posedge sys_clk_i) |reload_o);
endmodule // dmacm_top

// ### hdl/dmacm_pkg.sv
// Constants for the DMA command and mask port logic.
// Assumes an 8-bit I/O port bus on the core clock.
//
// What this block does
// - Byte-pointer clear write resets byte select.
// - Reset and controller clear clear byte select.
// - After clear, low byte then high byte.
// - Controller clear acts like hardware reset.
// - Clear strobes ctrl_clear_o, zeros reload, sets masks.
// - Clear-mask write unmasks all four channels.
// - All-mask write loads bits 3:0 as masks.
// - All-mask read returns four mask bits.
// - Bit n is channel n or n+4.
// - Terminal count sets mask unless autoinit.
// - Reset leaves all-mask reading 0000 1111.
// - Masking channel 4 blocks channels 0-3.
// - Single-mask write sets/clears one chosen mask.
// - Autoinit terminal count reloads current registers.
package dmacm_pkg;
  // ---------------------------------------------------
  // Port addresses
  // ---------------------------------------------------
  localparam logic [15:0] ADDR_SMASK_LO = 16'h000A;
  localparam logic [15:0] ADDR_BPCLR_LO = 16'h000C;
  localparam logic [15:0] ADDR_CCLR_LO  = 16'h000D;
  localparam logic [15:0] ADDR_CMASK_LO = 16'h000E;
  localparam logic [15:0] ADDR_AMASK_LO = 16'h000F;
  localparam logic [15:0] ADDR_SMASK_HI = 16'h00D4;
  localparam logic [15:0] ADDR_BPCLR_HI = 16'h00D8;
  localparam logic [15:0] ADDR_CCLR_HI  = 16'h00DA;
  localparam logic [15:0] ADDR_CMASK_HI = 16'h00DC;
  localparam logic [15:0] ADDR_AMASK_HI = 16'h00DE;
  // ---------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------
  localparam int          SMASK_SET_BIT = 2;
  localparam logic [3:0]  MASK_RESET    = 4'hF;
  localparam logic [3:0]  MASK_CLEAR    = 4'h0;
  localparam int          CASCADE_CH    = 0;
endpackage

// ### bench/dmacm_host.sv
// Host model: byte-wide I/O port master for the command and mask ports.
// Assumes callers are aligned to the falling edge of sys_clk_i.
`timescale 1ns/1ps
module dmacm_host (
  // Clock
  input  wire logic        sys_clk_i,
  // I/O port
  output logic      [15:0] io_addr_o,
  output logic             io_wr_o,
  output logic             io_rd_o,
  output logic      [7:0]  io_wdata_o,
  input  wire logic [7:0]  io_rdata_i,
  input  wire logic        io_rvalid_i
);
  initial begin
    io_addr_o  = 16'h0000;
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_wdata_o = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    io_addr_o  = a;
    io_wdata_o = d;
    io_wr_o    = 1'b1;
    @(negedge sys_clk_i);
    io_wr_o    = 1'b0;
    // Released bus shows inverted leftovers, never the last value
    io_addr_o  = ~a;
    io_wdata_o = ~d;
  endtask
  task automatic amask(input logic [15:0] a, input logic [3:0] m);
    wr(a, {4'h0, m});
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge sys_clk_i);
    io_addr_o = a;
    io_rd_o   = 1'b1;
    @(negedge sys_clk_i);
    d         = io_rdata_i;
    v         = io_rvalid_i;
    io_rd_o   = 1'b0;
    io_addr_o = ~a;
  endtask
endmodule // dmacm_host

// ### bench/testbench.sv
// Self-checking bench for the command and mask ports.
// Assumes the host model drives the I/O port; engine inputs driven here.
`timescale 1ns/1ps
module testbench;
  import dmacm_pkg::*;
  logic        sys_clk, rst, wr, rd, rvalid;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, tc, ai, req, mask, reload, req_ok;
  logic [1:0]  acc, byte_hi, cclr;
  int          bad_count, comparisons;
  dmacm_top i_dmacm_top (.sys_clk_i(sys_clk), .rst_i(rst), .io_addr_i(addr), .io_wr_i(wr),
    .io_rd_i(rd), .io_wdata_i(wdata), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
    .reg16_acc_i(acc), .terminal_count_i(tc), .autoinit_i(ai), .channel_request_i(req),
    .byte_hi_o(byte_hi), .mask_o(mask), .ctrl_clear_o(cclr), .reload_o(reload),
    .request_ok_o(req_ok));
  dmacm_host i_dmacm_host (.sys_clk_i(sys_clk), .io_addr_o(addr), .io_wr_o(wr), .io_rd_o(rd),
    .io_wdata_o(wdata), .io_rdata_i(rdata), .io_rvalid_i(rvalid));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_dmacm_host.rd(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask
  task automatic pulse(input logic [1:0] a, input logic [7:0] t);
    @(negedge sys_clk);
    acc = a;
    tc  = t;
    @(negedge sys_clk);
    acc = 2'h0;
    tc  = 8'h00;
  endtask
  task automatic t_reset();
    chk(mask, 8'hFF);
    chk({6'h00, byte_hi}, 8'h00);
    rdchk(ADDR_AMASK_LO, 8'h0F);
    rdchk(ADDR_AMASK_HI, 8'h0F);
    rdchk(16'h0010, 8'h00);
  endtask
  task automatic t_bptr();
    for (int k = 0; k < 2; k++) begin
      pulse(2'h1 << k, 8'h00);
      chk({6'h00, byte_hi}, 8'h01 << k);
      pulse(2'h1 << k, 8'h00);
      chk({6'h00, byte_hi}, 8'h00);
      pulse(2'h1 << k, 8'h00);
      i_dmacm_host.wr(k ? ADDR_BPCLR_HI : ADDR_BPCLR_LO, 8'hA5);
      chk({6'h00, byte_hi}, 8'h00);
    end
  endtask
  task automatic t_masks();
    i_dmacm_host.amask(ADDR_AMASK_LO, 4'h5);
    i_dmacm_host.amask(ADDR_AMASK_HI, 4'hA);
    chk(mask, 8'hA5);
    rdchk(ADDR_AMASK_LO, 8'h05);
    rdchk(ADDR_AMASK_HI, 8'h0A);
    i_dmacm_host.wr(ADDR_CMASK_LO, 8'hFF);
    chk(mask, 8'hA0);
    i_dmacm_host.wr(ADDR_CMASK_HI, 8'h00);
    chk(mask, 8'h00);
    i_dmacm_host.wr(ADDR_SMASK_LO, 8'h06);
    chk(mask, 8'h04);
    i_dmacm_host.wr(ADDR_SMASK_HI, 8'h07);
    chk(mask, 8'h84);
    i_dmacm_host.wr(ADDR_SMASK_HI, 8'h03);
    chk(mask, 8'h04);
  endtask
  task automatic t_cascade_tc();
    req = 8'hFF;
    // Requests pass the pin synchroniser first
    repeat (5) @(negedge sys_clk);
    chk(req_ok, 8'hFB);
    i_dmacm_host.wr(ADDR_SMASK_HI, 8'h04);
    chk(req_ok, 8'hE0);
    ai = 8'h02;
    pulse(2'h0, 8'h13);
    chk(mask, 8'h15);
    chk(reload, 8'h02);
    @(negedge sys_clk);
    chk(reload, 8'h00);
  endtask
  task automatic t_cclr();
    pulse(2'h2, 8'h00);
    i_dmacm_host.wr(ADDR_CCLR_HI, 8'h3C);
    chk(mask, 8'hF5);
    chk({6'h00, byte_hi}, 8'h00);
    chk({6'h00, cclr}, 8'h02);
    @(negedge sys_clk);
    chk({6'h00, cclr}, 8'h00);
    pulse(2'h1, 8'h00);
    i_dmacm_host.wr(ADDR_CCLR_LO, 8'h00);
    chk(mask, 8'hFF);
    chk({6'h00, byte_hi}, 8'h00);
    chk({6'h00, cclr}, 8'h01);
    chk(reload, 8'h00);
  endtask
  initial begin
    bad_count   = 0;
    comparisons = 0;
    rst = 1'b1;
    acc = 2'h0;
    tc  = 8'h00;
    ai  = 8'h00;
    req = 8'h00;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_bptr();
    t_masks();
    t_cascade_tc();
    t_cclr();
    close_out();
  end
  // Watchdog well beyond the roughly 60 cycles the tests need
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule // testbench
